/* File: src/config_page3_loader.v */
// The strobed register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "config_page3_map.vh"
module config_page3_loader #(
   parameter AW = 16,
   parameter DW = 16,
   parameter WORDS = 8,
   parameter IW = 3
) (
   input wire core_clk,
   input wire srst,
   input wire [AW-1:0] reg_addr,
   input wire [DW-1:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output wire [DW-1:0] reg_rdata,
   input wire power_on_sched,
   input wire dev_mode,
   output reg otp_req_q,
   output reg otp_we_q,
   output reg [IW-1:0] otp_addr_q,
   output reg [DW-1:0] otp_wdata_q,
   input wire otp_ack,
   input wire [DW-1:0] otp_rdata,
   output reg ext_req_q,
   output reg [7:0] ext_addr_q,
   input wire ext_ack,
   input wire [7:0] ext_rdata,
   output reg page_busy_q
);
   // ==========================================
   // Engine states
   localparam S_IDLE = 3'h0;
   localparam S_OTP_RD = 3'h1;
   localparam S_FETCH = 3'h2;
   localparam S_FETCH_W = 3'h3;
   localparam S_OTP_WR = 3'h4;
   localparam S_EXT_HI = 3'h5;
   localparam S_EXT_LO = 3'h6;

   reg [2:0] state_q;
   reg [IW-1:0] idx_q;
   reg [7:0] hi_q;
   reg reload_q;
   reg [1:0] src_q;
   reg skip_q;
   localparam [15:0] CTRL_RST_W = `CTRL_RST;

   // ==========================================
   // Address decode
   wire in_pg3 = (reg_addr & `PG3_MASK) == `PG3_BASE;
   wire in_alias = (reg_addr & `PG3_MASK) == `MAIN_ALIAS_BASE;
   wire hit_page = in_pg3 | in_alias;
   wire hit_ctrl = reg_addr == `CTRL_ADDR;
   wire hit_cmd = reg_addr == `CMD_ADDR;
   wire hit_stat = reg_addr == `STAT_ADDR;
   wire idle = state_q == S_IDLE;
   wire last = idx_q == WORDS - 1;

   // Page writes are refused while a load or store runs, so the
   // page never mixes bus data with half a transfer
   wire bus_page_wr = reg_wr & hit_page & idle;

   // ==========================================
   // Start conditions, power-on wins over commands
   wire cmd_wr = reg_wr & hit_cmd & idle;
   wire po_go = power_on_sched & idle & reload_q;
   wire start_otp_rd = (po_go & ~dev_mode) |
      (~power_on_sched & cmd_wr & reg_wdata[`CMD_OTP_RD_BIT]);
   wire start_ext = (po_go & dev_mode) |
      (~power_on_sched & cmd_wr & ~reg_wdata[`CMD_OTP_RD_BIT] &
       reg_wdata[`CMD_EXT_RD_BIT]);
   wire start_otp_wr = ~power_on_sched & cmd_wr & ~reg_wdata[`CMD_OTP_RD_BIT] &
      ~reg_wdata[`CMD_EXT_RD_BIT] & reg_wdata[`CMD_OTP_WR_BIT];
   wire po_skip = power_on_sched & idle & ~reload_q;

   // ==========================================
   // Storage write mux
   wire eng_otp_we = (state_q == S_OTP_RD) & otp_req_q & otp_ack;
   wire eng_ext_we = (state_q == S_EXT_LO) & ext_req_q & ext_ack;
   reg mem_we;
   reg [IW-1:0] mem_widx;
   reg [DW-1:0] mem_wdata;

   always @* begin
      mem_we = 1'b0;
      mem_widx = reg_addr[IW-1:0];
      mem_wdata = reg_wdata;
      if (eng_otp_we) begin
         mem_we = 1'b1;
         mem_widx = idx_q;
         mem_wdata = otp_rdata;
      end else if (eng_ext_we) begin
         mem_we = 1'b1;
         mem_widx = idx_q;
         mem_wdata = {hi_q, ext_rdata};
      end else if (bus_page_wr) begin
         // Whole words stored, so slot fields keep their bit places
         mem_we = 1'b1;
      end
   end

   // ==========================================
   // Non-page read data
   reg [DW-1:0] alt_data;
   wire [DW-1:0] fetch_q;

   always @* begin
      alt_data = {DW{1'b0}};
      if (hit_ctrl) begin
         alt_data[`CTRL_RELOAD_BIT] = reload_q;
      end else if (hit_stat) begin
         alt_data[`STAT_BUSY_BIT] = page_busy_q;
         alt_data[`STAT_SRC_MSB:`STAT_SRC_LSB] = src_q;
         alt_data[`STAT_SKIP_BIT] = skip_q;
      end
   end

   page_store #(
      .DW(DW),
      .WORDS(WORDS),
      .IW(IW)
   ) u_store (
      .core_clk(core_clk),
      .srst(srst),
      .wr_en(mem_we),
      .wr_idx(mem_widx),
      .wr_data(mem_wdata),
      .a_rd(reg_rd),
      .a_idx(reg_addr[IW-1:0]),
      .a_alt_sel(~hit_page),
      .a_alt_data(alt_data),
      .a_q(reg_rdata),
      .b_rd(state_q == S_FETCH),
      .b_idx(idx_q),
      .b_q(fetch_q)
   );

   // ==========================================
   // Control and status registers
   always @(posedge core_clk) begin
      if (srst) begin
         reload_q <= CTRL_RST_W[`CTRL_RELOAD_BIT];
         skip_q <= 1'b0;
      end else begin
         if (reg_wr & hit_ctrl) begin
            reload_q <= reg_wdata[`CTRL_RELOAD_BIT];
         end
         // Set wins over a clear in the same cycle
         if (po_skip) begin
            skip_q <= 1'b1;
         end else if (reg_wr & hit_stat & reg_wdata[`STAT_SKIP_BIT]) begin
            skip_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // Load and store engine
   always @(posedge core_clk) begin
      if (srst) begin
         state_q <= S_IDLE;
         idx_q <= {IW{1'b0}};
         hi_q <= 8'h00;
         src_q <= `SRC_NONE;
         page_busy_q <= 1'b0;
         otp_req_q <= 1'b0;
         otp_we_q <= 1'b0;
         otp_addr_q <= {IW{1'b0}};
         otp_wdata_q <= {DW{1'b0}};
         ext_req_q <= 1'b0;
         ext_addr_q <= 8'h00;
      end else begin
         if (bus_page_wr) begin
            src_q <= `SRC_BUS;
         end
         case (state_q)
            S_IDLE: begin
               idx_q <= {IW{1'b0}};
               if (start_otp_rd) begin
                  state_q <= S_OTP_RD;
                  page_busy_q <= 1'b1;
                  otp_req_q <= 1'b1;
                  otp_we_q <= 1'b0;
                  otp_addr_q <= {IW{1'b0}};
               end else if (start_ext) begin
                  state_q <= S_EXT_HI;
                  page_busy_q <= 1'b1;
                  ext_req_q <= 1'b1;
                  ext_addr_q <= `EXT_PAGE_BASE;
               end else if (start_otp_wr) begin
                  state_q <= S_FETCH;
                  page_busy_q <= 1'b1;
               end
            end
            S_OTP_RD: begin
               // Request drops for a cycle after each ack but the last
               if (otp_req_q & otp_ack) begin
                  otp_req_q <= 1'b0;
                  if (last) begin
                     state_q <= S_IDLE;
                     page_busy_q <= 1'b0;
                     src_q <= `SRC_OTP;
                  end else begin
                     idx_q <= idx_q + 1'b1;
                  end
               end else if (~otp_req_q) begin
                  otp_req_q <= 1'b1;
                  otp_addr_q <= idx_q;
               end
            end
            S_FETCH: begin
               state_q <= S_FETCH_W;
            end
            S_FETCH_W: begin
               state_q <= S_OTP_WR;
               otp_req_q <= 1'b1;
               otp_we_q <= 1'b1;
               otp_addr_q <= idx_q;
               otp_wdata_q <= fetch_q;
            end
            S_OTP_WR: begin
               if (otp_ack) begin
                  otp_req_q <= 1'b0;
                  otp_we_q <= 1'b0;
                  if (last) begin
                     state_q <= S_IDLE;
                     page_busy_q <= 1'b0;
                  end else begin
                     idx_q <= idx_q + 1'b1;
                     state_q <= S_FETCH;
                  end
               end
            end
            S_EXT_HI: begin
               if (ext_req_q & ext_ack) begin
                  hi_q <= ext_rdata;
                  ext_req_q <= 1'b0;
                  state_q <= S_EXT_LO;
               end else if (~ext_req_q) begin
                  ext_req_q <= 1'b1;
                  ext_addr_q <= `EXT_PAGE_BASE + {4'h0, idx_q, 1'b0};
               end
            end
            S_EXT_LO: begin
               if (ext_req_q & ext_ack) begin
                  ext_req_q <= 1'b0;
                  if (last) begin
                     state_q <= S_IDLE;
                     page_busy_q <= 1'b0;
                     src_q <= `SRC_EXT;
                  end else begin
                     idx_q <= idx_q + 1'b1;
                     state_q <= S_EXT_HI;
                  end
               end else if (~ext_req_q) begin
                  ext_req_q <= 1'b1;
                  ext_addr_q <= `EXT_PAGE_BASE + {4'h0, idx_q, 1'b1};
               end
            end
            default: begin
               state_q <= S_IDLE;
               page_busy_q <= 1'b0;
               otp_req_q <= 1'b0;
               otp_we_q <= 1'b0;
               ext_req_q <= 1'b0;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: src/config_page3_map.vh */
`ifndef CONFIG_PAGE3_MAP_VH
`define CONFIG_PAGE3_MAP_VH
// ==========================================
// Page location in the config shadow window
`define PG3_BASE 16'h7818
`define PG3_LAST 16'h781f
`define PG3_MASK 16'hfff8
// Duplicate of the page in the main register area
`define MAIN_ALIAS_BASE 16'h4018
// ==========================================
// Control, command and status registers
`define CTRL_ADDR 16'h7830
`define CMD_ADDR 16'h7831
`define STAT_ADDR 16'h7832
`define CTRL_RST 16'h0001
`define CTRL_RELOAD_BIT 0
`define CMD_OTP_RD_BIT 0
`define CMD_OTP_WR_BIT 1
`define CMD_EXT_RD_BIT 2
`define STAT_BUSY_BIT 0
`define STAT_SRC_LSB 1
`define STAT_SRC_MSB 2
`define STAT_SKIP_BIT 3
// ==========================================
// Load source codes
`define SRC_NONE 2'h0
`define SRC_OTP 2'h1
`define SRC_EXT 2'h2
`define SRC_BUS 2'h3
// ==========================================
// External memory page and field layout
`define EXT_PAGE_BASE 8'h10
`define EXT_PAGE_LAST 8'h1f
`define SLOT_MSB 2
`define SLOT_LSB 0
`endif

/* File: src/page_store.v */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Page storage, two registered read ports
module page_store #(
   parameter DW = 16,
   parameter WORDS = 8,
   parameter IW = 3
) (
   input wire core_clk,
   input wire srst,
   input wire wr_en,
   input wire [IW-1:0] wr_idx,
   input wire [DW-1:0] wr_data,
   input wire a_rd,
   input wire [IW-1:0] a_idx,
   input wire a_alt_sel,
   input wire [DW-1:0] a_alt_data,
   output reg [DW-1:0] a_q,
   input wire b_rd,
   input wire [IW-1:0] b_idx,
   output reg [DW-1:0] b_q
);
   reg [DW-1:0] mem [0:WORDS-1];
   integer i;

   always @(posedge core_clk) begin
      if (srst) begin
         for (i = 0; i < WORDS; i = i + 1) begin
            mem[i] <= {DW{1'b0}};
         end
         a_q <= {DW{1'b0}};
         b_q <= {DW{1'b0}};
      end else begin
         if (wr_en) begin
            mem[wr_idx] <= wr_data;
         end
         // Zero outside a read so stale data never looks valid
         if (a_rd) begin
            a_q <= a_alt_sel ? a_alt_data : mem[a_idx];
         end else begin
            a_q <= {DW{1'b0}};
         end
         if (b_rd) begin
            b_q <= mem[b_idx];
         end
      end
   end
endmodule
`default_nettype wire

/* File: verification/cfg_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// OTP and external memory stand-in
module cfg_mem_model (
   input wire logic core_clk,
   input wire logic [3:0] dly,
   input wire logic otp_req_q,
   input wire logic otp_we_q,
   input wire logic [2:0] otp_addr_q,
   input wire logic [15:0] otp_wdata_q,
   output logic otp_ack,
   output logic [15:0] otp_rdata,
   input wire logic ext_req_q,
   input wire logic [7:0] ext_addr_q,
   output logic ext_ack,
   output logic [7:0] ext_rdata
);
   logic [15:0] otp [0:7];
   logic [7:0] ext [0:31];
   logic [3:0] oc;
   logic [3:0] ec;
   // Inverted outside ack so a stale word never passes
   assign otp_rdata = otp_ack ? otp[otp_addr_q] : ~otp[otp_addr_q];
   assign ext_rdata = ext_ack ? ext[ext_addr_q[4:0]] : ~ext[ext_addr_q[4:0]];
   always @(posedge core_clk) begin
      otp_ack <= otp_req_q && !otp_ack && oc >= dly;
      oc <= (otp_req_q && !otp_ack) ? oc + 4'h1 : 4'h0;
      if (otp_req_q && otp_we_q && otp_ack) begin
         otp[otp_addr_q] <= otp_wdata_q;
      end
      ext_ack <= ext_req_q && !ext_ack && ec >= dly;
      ec <= (ext_req_q && !ext_ack) ? ec + 4'h1 : 4'h0;
   end
endmodule
`default_nettype wire

/* File: verification/page3_checker_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "config_page3_map.vh"
// ==========================================
// Port checks of the page loader
module page3_checker #(
   parameter AW = 16,
   parameter DW = 16,
   parameter IW = 3
) (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [AW-1:0] reg_addr,
   input wire logic [DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DW-1:0] reg_rdata,
   input wire logic power_on_sched,
   input wire logic dev_mode,
   input wire logic otp_req_q,
   input wire logic otp_we_q,
   input wire logic [IW-1:0] otp_addr_q,
   input wire logic [DW-1:0] otp_wdata_q,
   input wire logic otp_ack,
   input wire logic [DW-1:0] otp_rdata,
   input wire logic ext_req_q,
   input wire logic [7:0] ext_addr_q,
   input wire logic ext_ack,
   input wire logic [7:0] ext_rdata,
   input wire logic page_busy_q
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);
   sequence ext_gap; !ext_req_q ##1 ext_req_q; endsequence
   sequence otp_gap1; !otp_req_q ##1 otp_req_q; endsequence
   // Program steps leave room for the word fetch
   sequence otp_gap2; !otp_req_q [*2] ##1 otp_req_q; endsequence
   a_otp_req_hold: assert property (
      otp_req_q && !otp_ack |=> otp_req_q && $stable(otp_addr_q) && $stable(otp_we_q)
      && $stable(otp_wdata_q)) else $error("otp request changed before ack");
   a_otp_req_drop: assert property (
      otp_req_q && otp_ack |=> !otp_req_q) else $error("otp request held after ack");
   a_otp_rd_step: assert property (
      otp_req_q && otp_ack && !otp_we_q && otp_addr_q != 3'h7 |=> otp_gap1 ##0
      (!otp_we_q && otp_addr_q == $past(otp_addr_q, 2) + 3'h1)) else $error("otp read order");
   a_otp_wr_step: assert property (
      otp_req_q && otp_ack && otp_we_q && otp_addr_q != 3'h7 |=> otp_gap2 ##0
      (otp_we_q && otp_addr_q == $past(otp_addr_q, 3) + 3'h1)) else $error("otp write order");
   a_ext_req_hold: assert property (
      ext_req_q && !ext_ack |=> ext_req_q && $stable(ext_addr_q)) else $error("ext req moved");
   a_ext_addr_range: assert property (
      ext_req_q |-> ext_addr_q >= `EXT_PAGE_BASE && ext_addr_q <= `EXT_PAGE_LAST)
      else $error("ext address outside page");
   a_ext_byte_step: assert property (
      ext_req_q && ext_ack && ext_addr_q != `EXT_PAGE_LAST |=> ext_gap ##0
      (ext_addr_q == $past(ext_addr_q, 2) + 8'h01)) else $error("ext byte order");
   a_ext_cmd_start: assert property (
      reg_wr && reg_addr == `CMD_ADDR && reg_wdata == 16'h0004 && !page_busy_q && !power_on_sched
      |=> ext_req_q && ext_addr_q == `EXT_PAGE_BASE) else $error("ext load start");
   a_rdata_idle: assert property (
      !$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("read data outside slot");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "config_page3_map.vh"
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin err_total++; \
   $display("unexpected t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
   logic core_clk, srst, reg_wr, reg_rd, power_on_sched, dev_mode;
   logic [15:0] reg_addr, reg_wdata, rv;
   logic [15:0] exp_w [0:7];
   logic [3:0] dly;
   wire [15:0] reg_rdata, otp_wdata_q, otp_rdata;
   wire otp_req_q, otp_we_q, otp_ack, ext_req_q, ext_ack, page_busy_q;
   wire [2:0] otp_addr_q;
   wire [7:0] ext_addr_q, ext_rdata;
   int err_total = 0;
   int check_count = 0;
   config_page3_loader config_page3_loader_inst (.core_clk(core_clk), .srst(srst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .power_on_sched(power_on_sched), .dev_mode(dev_mode),
      .otp_req_q(otp_req_q), .otp_we_q(otp_we_q), .otp_addr_q(otp_addr_q),
      .otp_wdata_q(otp_wdata_q), .otp_ack(otp_ack), .otp_rdata(otp_rdata),
      .ext_req_q(ext_req_q), .ext_addr_q(ext_addr_q), .ext_ack(ext_ack),
      .ext_rdata(ext_rdata), .page_busy_q(page_busy_q));
   cfg_mem_model cfg_mem_model_inst (.core_clk(core_clk), .dly(dly), .otp_req_q(otp_req_q),
      .otp_we_q(otp_we_q), .otp_addr_q(otp_addr_q), .otp_wdata_q(otp_wdata_q),
      .otp_ack(otp_ack), .otp_rdata(otp_rdata), .ext_req_q(ext_req_q),
      .ext_addr_q(ext_addr_q), .ext_ack(ext_ack), .ext_rdata(ext_rdata));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task stop_test;
      $display("mismatches %0d checks %0d", err_total, check_count);
      if (err_total == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task rd(input logic [15:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   // Bounded so a stuck loader ends the run
   task wait_idle;
      repeat (2) @(posedge core_clk);
      for (int n = 0; n < 400 && page_busy_q !== 1'b0; n++) @(posedge core_clk);
      if (page_busy_q !== 1'b0) begin
         err_total++;
         stop_test;
      end
   endtask
   task pulse_on;
      @(posedge core_clk);
      power_on_sched <= 1'b1;
      @(posedge core_clk);
      power_on_sched <= 1'b0;
      wait_idle;
   endtask
   task chk_page(input logic [15:0] base);
      for (int k = 0; k < 8; k++) begin
         rd(base + k[15:0]);
         `CHK(rv, exp_w[k])
      end
   endtask
   task set_otp(input logic [15:0] b);
      for (int k = 0; k < 8; k++) cfg_mem_model_inst.otp[k] = b + k[15:0];
      for (int k = 0; k < 8; k++) exp_w[k] = b + k[15:0];
   endtask
   task set_ext(input logic [7:0] b);
      for (int k = 0; k < 16; k++) cfg_mem_model_inst.ext[16 + k] = b + k[7:0];
      for (int k = 0; k < 8; k++) exp_w[k] = {b + 8'(2 * k), b + 8'(2 * k + 1)};
   endtask
   task t_reset_values;
      rd(`CTRL_ADDR);
      `CHK(rv, `CTRL_RST)
      rd(16'h7833);
      `CHK(rv, 16'h0000)
   endtask
   task t_otp_read;
      set_otp(16'h1230);
      wr(`CMD_ADDR, 16'h0001);
      wait_idle;
      chk_page(`PG3_BASE);
      // Idle, last source OTP
      rd(`STAT_ADDR);
      `CHK(rv, 16'h0002)
   endtask
   task t_ext_read;
      dly <= 4'h3;
      set_ext(8'ha0);
      wr(`CMD_ADDR, 16'h0004);
      wait_idle;
      chk_page(`PG3_BASE);
      chk_page(`MAIN_ALIAS_BASE);
      // Idle, last source external
      rd(`STAT_ADDR);
      `CHK(rv, 16'h0004)
   endtask
   task t_bus_otp_write;
      for (int k = 0; k < 8; k++) exp_w[k] = 16'h5a00 + k[15:0];
      for (int k = 0; k < 7; k++) wr(`PG3_BASE + k[15:0], exp_w[k]);
      wr(`MAIN_ALIAS_BASE + 16'h0007, exp_w[7]);
      // Low three bits carry the word index, so slot fields stay put
      chk_page(`PG3_BASE);
      rd(`STAT_ADDR);
      `CHK(rv, 16'h0006)
      wr(`CMD_ADDR, 16'h0002);
      wait_idle;
      for (int k = 0; k < 8; k++) `CHK(cfg_mem_model_inst.otp[k], exp_w[k])
   endtask
   task t_power_on;
      set_otp(16'hc3c0);
      pulse_on;
      chk_page(`PG3_BASE);
      dev_mode <= 1'b1;
      set_ext(8'h31);
      pulse_on;
      chk_page(`PG3_BASE);
      dev_mode <= 1'b0;
      wr(`CTRL_ADDR, 16'h0000);
      pulse_on;
      chk_page(`PG3_BASE);
      rd(`STAT_ADDR);
      `CHK(rv[`STAT_SKIP_BIT], 1'b1)
   endtask
   initial begin
      srst = 1'b1;
      {reg_wr, reg_rd, power_on_sched, dev_mode} = 4'h0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
      dly = 4'h0;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      t_reset_values;
      t_otp_read;
      t_ext_read;
      t_bus_otp_write;
      t_power_on;
      stop_test;
   end
endmodule
bind config_page3_loader page3_checker #(.AW(AW), .DW(DW), .IW(IW)) page3_checker_inst (
   .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_on_sched(power_on_sched),
   .dev_mode(dev_mode), .otp_req_q(otp_req_q), .otp_we_q(otp_we_q), .otp_addr_q(otp_addr_q),
   .otp_wdata_q(otp_wdata_q), .otp_ack(otp_ack), .otp_rdata(otp_rdata),
   .ext_req_q(ext_req_q), .ext_addr_q(ext_addr_q), .ext_ack(ext_ack),
   .ext_rdata(ext_rdata), .page_busy_q(page_busy_q));
`default_nettype wire
